// ---- tb/drive_fault_class_responder_test.sv ----
// Self-checking bench for the drive fault class responder.
// Assumes the package, lamp_blinker and panel_model are compiled first.
module drive_fault_class_responder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_class_pkg::*;
  logic ref_clk = 0, rst = 1, f_det = 0, f_rst = 0, ramp = 0, minor = 0;
  logic alarm = 0, conf = 0, hwm = 0, tun = 0, terr = 0, run = 0;
  logic dwe = 0, clr = 0;
  logic [CODE_W-1:0] fcode = 0, acode = 0, ocode = 0, tcode = 0, disp;
  logic [SEL_W-1:0] s0 = SEL_FAULT, s1 = SEL_MINOR, s2 = 5'h00;
  logic [1:0] dsel = 2'h0;
  logic [NUM_OUT-1:0] contact;
  logic lamp, den, coast, rstop, sacc, sdec;
  int mismatches = 0, samples_checked = 0, cycles = 0, toggles;

  drive_fault_class_responder #(.HALF_PERIOD(4)) uut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_fault_det(f_det),
    .i_fault_code(fcode), .i_fault_reset(f_rst), .i_stop_ramp(ramp),
    .i_minor_det(minor), .i_alarm_det(alarm), .i_alarm_code(acode),
    .i_param_conflict(conf), .i_hw_mismatch(hwm), .i_operr_code(ocode),
    .i_tuning(tun), .i_tune_err_det(terr), .i_tune_code(tcode),
    .i_run_req(run), .i_func_sel0(s0), .i_func_sel1(s1),
    .i_func_sel2(s2), .i_dstall_sel_wr(dsel), .i_dstall_we(dwe),
    .o_disp_code(disp), .o_alert_lamp(lamp), .o_contact(contact),
    .o_drive_enable(den), .o_coast(coast), .o_ramp_stop(rstop),
    .o_stall_accel_en(sacc), .o_stall_decel_en(sdec)
  );
  panel_model panel (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_lamp(lamp), .i_clear(clr),
    .o_toggles(toggles)
  );

  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Checks sit mid-cycle so every edge's updates have landed.
  task automatic look;
    @(negedge ref_clk);
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run needs about 120 cycles, well within the 2000-cycle limit.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    rst <= 0;
    cyc(2);
    look;
    chk("stall_acc", 1, sacc);
    chk("stall_dec", 1, sdec);
    cyc(1);
    dsel <= DSTALL_DISABLE;
    dwe <= 1;
    cyc(1);
    dwe <= 0;
    cyc(1);
    look;
    chk("stall_dec_off", 0, sdec);
    cyc(1);
    dsel <= DSTALL_RESET_VAL;
    dwe <= 1;
    run <= 1;
    cyc(1);
    dwe <= 0;
    cyc(2);
    look;
    chk("stall_dec_on", 1, sdec);
    chk("run_idle", 1, den);
    // Second pass uses ramp stop and an alarm raised with the fault.
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      ramp <= k[0];
      alarm <= k[0];
      acode <= 8'h55;
      fcode <= 8'h21 + 8'(k);
      f_det <= 1;
      clr <= 1;
      cyc(1);
      f_det <= 0;
      clr <= 0;
      cyc(12);
      look;
      chk("fault_code", 8'h21 + 8'(k), disp);
      chk("fault_lamp", 1, lamp);
      chk("lamp_changes", 1, 8'(toggles));
      chk("fault_out", 3'b001, contact);
      chk("fault_run", 0, den);
      chk("coast", !k[0], coast);
      chk("ramp_stop", k[0], rstop);
      cyc(1);
      f_rst <= 1;
      alarm <= 0;
      cyc(1);
      f_rst <= 0;
      cyc(2);
      look;
      chk("reset_code", 0, disp);
      chk("reset_lamp", 0, lamp);
      chk("reset_out", 0, contact);
      chk("reset_run", 1, den);
    end
    cyc(1);
    minor <= 1;
    acode <= 8'h42;
    clr <= 1;
    cyc(1);
    clr <= 0;
    cyc(16);
    look;
    chk("minor_code", 8'h42, disp);
    chk("minor_flash", 1, toggles > 2);
    chk("minor_out", 3'b010, contact);
    chk("minor_run", 1, den);
    cyc(1);
    minor <= 0;
    alarm <= 1;
    cyc(3);
    look;
    chk("alarm_out", 0, contact);
    chk("alarm_run", 1, den);
    cyc(1);
    alarm <= 0;
    cyc(3);
    look;
    chk("alarm_gone", 0, disp);
    chk("alarm_lamp", 0, lamp);
    cyc(1);
    minor <= 1;
    cyc(2);
    conf <= 1;
    ocode <= 8'h63;
    cyc(1);
    minor <= 0;
    cyc(3);
    look;
    chk("operr_code", 8'h63, disp);
    chk("operr_out", 3'b010, contact);
    chk("operr_run", 0, den);
    cyc(1);
    conf <= 0;
    hwm <= 1;
    ocode <= 8'h64;
    cyc(3);
    look;
    chk("hw_code", 8'h64, disp);
    chk("hw_run", 0, den);
    cyc(1);
    hwm <= 0;
    cyc(3);
    look;
    chk("fixed_run", 1, den);
    cyc(1);
    minor <= 1;
    terr <= 1;
    tcode <= 8'h7a;
    cyc(3);
    look;
    chk("tune_idle", 8'h42, disp);
    chk("tune_idle_coast", 0, coast);
    cyc(1);
    tun <= 1;
    cyc(3);
    look;
    chk("tune_code", 8'h7a, disp);
    chk("tune_coast", 1, coast);
    chk("tune_out", 0, contact);
    cyc(1);
    tun <= 0;
    terr <= 0;
    minor <= 0;
    cyc(3);
    look;
    chk("tune_done", 0, coast);
    give_verdict;
  end
endmodule

// ---- tb/panel_model.sv ----
// Operator panel partner: watches the alert lamp line of the drive.
// Assumes the lamp is sampled on the drive control clock.
module panel_model (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_lamp, // alert lamp line
  input wire logic i_clear, // restart the change count
  output int o_toggles // lamp changes seen since clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lamp_ff;
  // Counting changes tells a steady lamp from a flashing one.
  always_ff @(posedge i_ref_clk) begin
    lamp_ff <= i_lamp;
    if (i_rst || i_clear) begin
      o_toggles <= 0;
    end else if (i_lamp != lamp_ff) begin
      o_toggles <= o_toggles + 1;
    end
  end
endmodule

// ---- verilog/drive_fault_class_responder.sv ----
// Classifies drive abnormal conditions and applies each class's response.
// Assumes condition inputs come from logic on i_ref_clk.
//
// Function
// RL1: Fault shows its code and holds the alert lamp steady until reset.
// RL2: Fault cuts power output at once; motor coasts unless stop method set.
// RL3: Contact outputs selected for fault function close while fault present.
// RL4: After a fault, motor run is refused until explicit reset.
// RL5: Alarm or minor fault shows its code and flashes the alert lamp.
// RL6: Alarm or minor fault does not stop the motor.
// RL7: Minor-fault selected outputs close on minor fault, not on alarm.
// RL8: Alarm indication clears by itself when its cause goes away.
// RL9: Conflicting or hardware-mismatched settings raise an operation error.
// RL10: Operation error shows its code and leaves contact outputs unchanged.
// RL11: Operation error blocks running until the settings are corrected.
// RL12: Tuning errors detected only during auto-tuning; show their code.
// RL13: Tuning error coasts motor and actuates no contact output.
// RL14: Stall prevention on by default; decel select zero disables it.
// RL15: Fault steady lamp wins over alarm flashing lamp.
module drive_fault_class_responder
  import fault_class_pkg::*;
#(
  parameter int HALF_PERIOD = fault_class_pkg::BLINK_CYCLES
) (
  input wire logic i_ref_clk, // 125 MHz clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_fault_det, // fault condition pulse or level
  input wire logic [fault_class_pkg::CODE_W-1:0] i_fault_code, // fault code
  input wire logic i_fault_reset, // fault reset command
  input wire logic i_stop_ramp, // configured stop method is ramp
  input wire logic i_minor_det, // minor fault condition level
  input wire logic i_alarm_det, // alarm condition level
  input wire logic [fault_class_pkg::CODE_W-1:0] i_alarm_code, // alarm code
  input wire logic i_param_conflict, // settings conflict each other
  input wire logic i_hw_mismatch, // settings disagree with hardware
  input wire logic [fault_class_pkg::CODE_W-1:0] i_operr_code, // op error
  input wire logic i_tuning, // auto-tuning in progress
  input wire logic i_tune_err_det, // tuning error condition
  input wire logic [fault_class_pkg::CODE_W-1:0] i_tune_code, // tune code
  input wire logic i_run_req, // run command
  input wire logic [fault_class_pkg::SEL_W-1:0] i_func_sel0, // out 0 func
  input wire logic [fault_class_pkg::SEL_W-1:0] i_func_sel1, // out 1 func
  input wire logic [fault_class_pkg::SEL_W-1:0] i_func_sel2, // out 2 func
  input wire logic [1:0] i_dstall_sel_wr, // new decel stall select value
  input wire logic i_dstall_we, // write strobe for decel stall select
  output logic [fault_class_pkg::CODE_W-1:0] o_disp_code, // display code
  output logic o_alert_lamp, // alert lamp
  output logic [fault_class_pkg::NUM_OUT-1:0] o_contact, // contact outputs
  output logic o_drive_enable, // power output enabled
  output logic o_coast, // output cut, motor coasting
  output logic o_ramp_stop, // output ramping to stop
  output logic o_stall_accel_en, // stall prevention in accel/run
  output logic o_stall_decel_en // stall prevention in decel
);
  import fault_class_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic [SEL_W-1:0] sel [NUM_OUT];
  resp_state_type state_ff, nxt_state;
  logic [CODE_W-1:0] code_ff, nxt_code;
  logic [NUM_OUT-1:0] contact_ff, nxt_contact;
  logic en_ff, nxt_en;
  logic coast_ff, nxt_coast;
  logic ramp_ff, nxt_ramp;
  logic [1:0] lamp_mode_ff, nxt_lamp_mode;
  logic [1:0] dstall_ff, nxt_dstall;
  logic dstall_en_ff, nxt_dstall_en;
  logic stall_acc_ff, nxt_stall_acc;
  logic operr;
  logic tune_err;
  logic alarm_any;

  assign sel[0] = i_func_sel0;
  assign sel[1] = i_func_sel1;
  assign sel[2] = i_func_sel2;
  assign operr = i_param_conflict | i_hw_mismatch; // RL9
  assign tune_err = i_tune_err_det & i_tuning; // RL12
  assign alarm_any = i_minor_det | i_alarm_det;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_fault_det) begin
          nxt_state = ST_FAULT;
        end else if (tune_err) begin
          nxt_state = ST_TUNERR;
        end else if (operr) begin
          nxt_state = ST_OPERR;
        end
      end
      ST_FAULT: begin
        // A reset while the cause persists is ignored; the fault stays latched.
        if (i_fault_reset && !i_fault_det) begin
          nxt_state = ST_IDLE; // RL4
        end
      end
      ST_OPERR: begin
        if (i_fault_det) begin
          nxt_state = ST_FAULT;
        end else if (!operr) begin
          nxt_state = ST_IDLE; // RL11
        end
      end
      ST_TUNERR: begin
        // Tuning error holds until the tuning run is abandoned.
        if (i_fault_det) begin
          nxt_state = ST_FAULT;
        end else if (!i_tuning) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_comb begin
    nxt_code = CODE_NONE;
    nxt_lamp_mode = LAMP_OFF;
    nxt_en = 1'b0;
    nxt_coast = 1'b0;
    nxt_ramp = 1'b0;
    nxt_contact = '0;
    case (nxt_state)
      ST_FAULT: begin
        nxt_code = (state_ff == ST_FAULT) ? code_ff : i_fault_code; // RL1
        nxt_lamp_mode = LAMP_STEADY; // RL15
        nxt_coast = ~i_stop_ramp; // RL2
        nxt_ramp = i_stop_ramp;
      end
      ST_OPERR: begin
        nxt_code = i_operr_code; // RL10
      end
      ST_TUNERR: begin
        nxt_code = (state_ff == ST_TUNERR) ? code_ff : i_tune_code; // RL12
        nxt_coast = 1'b1; // RL13
      end
      default: begin
        nxt_en = i_run_req; // RL6
        if (alarm_any) begin
          nxt_code = i_alarm_code; // RL5
          nxt_lamp_mode = LAMP_FLASH; // RL8
        end
      end
    endcase
    for (int k = 0; k < NUM_OUT; k++) begin
      if (nxt_state == ST_OPERR || nxt_state == ST_TUNERR) begin
        nxt_contact[k] = contact_ff[k]; // RL10
      end else if (nxt_state == ST_FAULT) begin
        nxt_contact[k] = (sel[k] == SEL_FAULT); // RL3
      end else begin
        nxt_contact[k] = (sel[k] == SEL_MINOR) & i_minor_det; // RL7
      end
    end
    if (nxt_state == ST_TUNERR) begin
      nxt_contact = '0; // RL13
    end
  end

  always_comb begin
    nxt_dstall = dstall_ff;
    if (i_dstall_we) begin
      nxt_dstall = i_dstall_sel_wr;
    end
    nxt_dstall_en = (nxt_dstall != DSTALL_DISABLE); // RL14
    nxt_stall_acc = 1'b1; // RL14
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      code_ff <= CODE_NONE;
      contact_ff <= '0;
      en_ff <= 1'b0;
      coast_ff <= 1'b0;
      ramp_ff <= 1'b0;
      lamp_mode_ff <= LAMP_OFF;
      dstall_ff <= DSTALL_RESET_VAL; // RL14
      dstall_en_ff <= 1'b1;
      stall_acc_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      contact_ff <= nxt_contact;
      en_ff <= nxt_en;
      coast_ff <= nxt_coast;
      ramp_ff <= nxt_ramp;
      lamp_mode_ff <= nxt_lamp_mode;
      dstall_ff <= nxt_dstall;
      dstall_en_ff <= nxt_dstall_en;
      stall_acc_ff <= nxt_stall_acc;
    end
  end

  lamp_blinker #(
    .HALF_PERIOD(HALF_PERIOD)
  ) u_lamp (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_mode(lamp_mode_ff),
    .o_lamp(o_alert_lamp)
  );

  assign o_disp_code = code_ff;
  assign o_contact = contact_ff;
  assign o_drive_enable = en_ff;
  assign o_coast = coast_ff;
  assign o_ramp_stop = ramp_ff;
  assign o_stall_accel_en = stall_acc_ff;
  assign o_stall_decel_en = dstall_en_ff;

  //////////////////////////////////////////////////////////////////////////
  sequence fault_seen_s;
    i_fault_det && !i_rst;
  endsequence

  fault_stop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    fault_seen_s |=> !o_drive_enable && (o_coast || o_ramp_stop)) // RL2
    else $error("fault did not stop drive output");

  fault_lamp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    fault_seen_s |=> ##1 o_alert_lamp) // RL1
    else $error("fault lamp not steady");

  fault_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_ff == ST_FAULT) && !i_fault_reset |=> state_ff == ST_FAULT) // RL4
    else $error("fault cleared without reset");

  fault_contact_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    fault_seen_s and (i_func_sel0 == SEL_FAULT) |=> o_contact[0]) // RL3
    else $error("fault contact not closed");

  minor_contact_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_IDLE && !i_fault_det && !tune_err && !operr &&
    i_alarm_det && !i_minor_det |=> o_contact == '0) // RL7
    else $error("alarm closed a contact");

  alarm_run_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_IDLE && !i_fault_det && !tune_err && !operr &&
    alarm_any && i_run_req |=> o_drive_enable) // RL6
    else $error("alarm stopped the motor");

  operr_block_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_OPERR |-> !o_drive_enable) // RL11
    else $error("motor ran during operation error");

  operr_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_OPERR && $past(state_ff) == ST_OPERR |->
    $stable(o_contact)) // RL10
    else $error("operation error changed contacts");

  tune_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_IDLE && !i_tuning && !i_fault_det |=>
    state_ff != ST_TUNERR) // RL12
    else $error("tuning error outside auto-tuning");

  tune_coast_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_ff == ST_TUNERR |-> o_coast && o_contact == '0) // RL13
    else $error("tuning error response wrong");

  dstall_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_dstall_we && i_dstall_sel_wr == DSTALL_DISABLE |=>
    !o_stall_decel_en) // RL14
    else $error("decel stall prevention not disabled");
endmodule

// ---- verilog/fault_class_pkg.sv ----
// Constants and types for the drive fault class responder.
// Assumes a single drive control clock and a synchronous reset.
package fault_class_pkg;
  localparam int CODE_W = 8;
  localparam int NUM_OUT = 3;
  localparam int SEL_W = 5;
  localparam logic [SEL_W-1:0] SEL_FAULT = 5'h0e;
  localparam logic [SEL_W-1:0] SEL_MINOR = 5'h10;
  localparam logic [1:0] DSTALL_DISABLE = 2'h0;
  localparam logic [1:0] DSTALL_RESET_VAL = 2'h1;
  localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = BLINK_MS * CLK_MHZ * 1000;
  localparam int BLINK_W = 26;
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_FLASH = 2'h1;
  localparam logic [1:0] LAMP_STEADY = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_FAULT, ST_OPERR, ST_TUNERR}
    resp_state_type;
endpackage

// ---- verilog/lamp_blinker.sv ----
// Alert lamp driver: off, flashing or steady.
// Assumes the mode input is registered on the same clock.
module lamp_blinker
  import fault_class_pkg::*;
#(
  parameter int HALF_PERIOD = BLINK_CYCLES
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst, // synchronous reset
  input wire logic [1:0] i_mode, // lamp mode
  output logic o_lamp // lamp drive
);
  logic [BLINK_W-1:0] cnt_ff;
  logic [BLINK_W-1:0] nxt_cnt;
  logic phase_ff;
  logic nxt_phase;
  logic lamp_ff;
  logic nxt_lamp;

  always_comb begin
    nxt_cnt = cnt_ff + 1'b1;
    nxt_phase = phase_ff;
    if (cnt_ff >= BLINK_W'(HALF_PERIOD - 1)) begin
      nxt_cnt = '0;
      nxt_phase = ~phase_ff;
    end
    if (i_mode == LAMP_STEADY) begin
      nxt_lamp = 1'b1;
    end else if (i_mode == LAMP_FLASH) begin
      nxt_lamp = phase_ff;
    end else begin
      nxt_lamp = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_ff <= '0;
      phase_ff <= 1'b1;
      lamp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
      lamp_ff <= nxt_lamp;
    end
  end

  assign o_lamp = lamp_ff;
endmodule
